// ===== hw/ps_pkg.sv
// Constants and types for the port status register
package ps_pkg;

    localparam int          DATA_W       = 16;
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  STATUS_ADDR  = 5'h01;

    // Field positions
    localparam int          T4_BIT       = 15;
    localparam int          CAP_HI       = 14;
    localparam int          CAP_LO       = 11;
    localparam int          RSV_HI       = 10;
    localparam int          RSV_LO       = 7;
    localparam int          PRE_BIT      = 6;
    localparam int          AN_DONE_BIT  = 5;
    localparam int          RFAULT_BIT   = 4;
    localparam int          AN_ABLE_BIT  = 3;
    localparam int          LINK_BIT     = 2;
    localparam int          JABBER_BIT   = 1;
    localparam int          EXT_BIT      = 0;

    // Reset and fixed values
    localparam logic [3:0]  CAP_RST      = 4'hF;
    localparam logic [3:0]  RSV_RST      = 4'h0;
    localparam logic        PRE_RST      = 1'h0;
    localparam logic        AN_DONE_RST  = 1'h0;
    localparam logic        RFAULT_RST   = 1'h0;
    localparam logic        LINK_RST     = 1'h0;
    localparam logic        JABBER_RST   = 1'h0;
    localparam logic        T4_VAL       = 1'h0;
    localparam logic        AN_ABLE_VAL  = 1'h1;
    localparam logic        EXT_VAL      = 1'h1;

    typedef struct packed {
        logic              rdStb;
        logic              wrStb;
        logic [4:0]        regAddr;
        logic [15:0]       wrData;
    } ps_mgmt_req_s;

    typedef struct packed {
        logic              linkValid;
        logic              remoteFault;
        logic              jabber;
        logic              anEnabled;
        logic              anComplete;
    } ps_line_s;

    typedef struct packed {
        logic [3:0]        cap;
        logic [3:0]        rsv;
        logic              preamble;
        logic              anDone;
        logic              rfault;
        logic              link;
        logic              jabber;
        logic [15:0]       rdData;
        logic              rdValid;
    } ps_state_s;

endpackage

// ===== hw/ps_status_reg.sv
// Port status register with latching status bits and override writes
`timescale 1ns/1ns
module ps_status_reg #(
    parameter int DATA_W = ps_pkg::DATA_W,
    parameter int ADDR_W = ps_pkg::ADDR_W
) (
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire ps_pkg::ps_mgmt_req_s mgmtReq,
    input  wire logic              altStatusRead,
    input  wire logic              overrideEn,
    input  wire ps_pkg::ps_line_s  line,
    output      logic [15:0]       rdData,
    output      logic              rdValid
);

    if (DATA_W != 16 || ADDR_W != 5) begin
        $error("ps_status_reg serves only 16-bit data, 5-bit address");
    end

    logic [1:0]        rstSync_ff;
    logic              rstnSync;
    ps_pkg::ps_state_s st_ff;
    ps_pkg::ps_state_s nxt_st;
    logic              selRead;
    logic              selWrite;
    logic              anyRead;
    logic [15:0]       view;

    // Reset release through two stages
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync_ff <= 2'h0;
        end else begin
            rstSync_ff <= {rstSync_ff[0], 1'b1};
        end
    end
    assign rstnSync = rstSync_ff[1];

    assign selRead  = mgmtReq.rdStb
                      && (mgmtReq.regAddr == ps_pkg::STATUS_ADDR);
    assign selWrite = mgmtReq.wrStb
                      && (mgmtReq.regAddr == ps_pkg::STATUS_ADDR);
    assign anyRead  = selRead || altStatusRead;

    // Live register image as the station sees it
    always_comb begin
        view                          = 16'h0000;
        view[ps_pkg::T4_BIT]          = ps_pkg::T4_VAL;
        view[ps_pkg::CAP_HI:ps_pkg::CAP_LO] = st_ff.cap;
        view[ps_pkg::RSV_HI:ps_pkg::RSV_LO] = st_ff.rsv;
        view[ps_pkg::PRE_BIT]         = st_ff.preamble;
        view[ps_pkg::AN_DONE_BIT]     = st_ff.anDone;
        view[ps_pkg::RFAULT_BIT]      = st_ff.rfault;
        view[ps_pkg::AN_ABLE_BIT]     = ps_pkg::AN_ABLE_VAL;
        view[ps_pkg::LINK_BIT]        = st_ff.link;
        view[ps_pkg::JABBER_BIT]      = st_ff.jabber;
        view[ps_pkg::EXT_BIT]         = ps_pkg::EXT_VAL;
    end

    always_comb begin
        nxt_st = st_ff;

        // Read returns the image, one cycle later
        nxt_st.rdValid = selRead;
        if (selRead) begin
            nxt_st.rdData = view;
        end

        // Override-writable fields; bit 15 has no storage
        if (selWrite && overrideEn) begin
            nxt_st.cap = mgmtReq.wrData[ps_pkg::CAP_HI:ps_pkg::CAP_LO];
            nxt_st.rsv = mgmtReq.wrData[ps_pkg::RSV_HI:ps_pkg::RSV_LO];
            nxt_st.preamble = mgmtReq.wrData[ps_pkg::PRE_BIT];
        end

        // Latch high: read clears, new event in same cycle wins
        if (anyRead) begin
            nxt_st.rfault = 1'b0;
            nxt_st.jabber = 1'b0;
        end
        if (line.remoteFault) begin
            nxt_st.rfault = 1'b1;
        end
        if (line.jabber) begin
            nxt_st.jabber = 1'b1;
        end

        // Negotiation done, forced low while negotiation disabled
        if (selRead) begin
            nxt_st.anDone = 1'b0;
        end
        if (line.anEnabled && line.anComplete) begin
            nxt_st.anDone = 1'b1;
        end
        if (!line.anEnabled) begin
            nxt_st.anDone = 1'b0;
        end

        // Latch low: read reloads the live level, any loss drops it
        if (selRead) begin
            nxt_st.link = line.linkValid;
        end
        if (!line.linkValid) begin
            nxt_st.link = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstnSync) begin
        if (!rstnSync) begin
            st_ff.cap      <= ps_pkg::CAP_RST;
            st_ff.rsv      <= ps_pkg::RSV_RST;
            st_ff.preamble <= ps_pkg::PRE_RST;
            st_ff.anDone   <= ps_pkg::AN_DONE_RST;
            st_ff.rfault   <= ps_pkg::RFAULT_RST;
            st_ff.link     <= ps_pkg::LINK_RST;
            st_ff.jabber   <= ps_pkg::JABBER_RST;
            st_ff.rdData   <= 16'h0000;
            st_ff.rdValid  <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdData  = st_ff.rdData;
    assign rdValid = st_ff.rdValid;

    // Checks

    a_reset_defaults: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        $rose(rstnSync) |-> (st_ff.cap == 4'hF && st_ff.rsv == 4'h0
            && !st_ff.preamble && !st_ff.anDone && !st_ff.link)
    ) else $error("status fields not at defaults after reset");

    a_read_returns: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        selRead |=> (rdValid && rdData == $past(view))
    ) else $error("status read did not return image next cycle");

    a_fixed_bits: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        rdValid |-> (!rdData[15] && rdData[3] && rdData[0])
    ) else $error("fixed status bits wrong");

    a_cap_blocked: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !(selWrite && overrideEn) |=> ($stable(st_ff.cap)
            && $stable(st_ff.rsv))
    ) else $error("override field changed without enabled write");

    a_cap_written: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (selWrite && overrideEn) |=>
            (st_ff.cap == $past(mgmtReq.wrData[14:11])
            && st_ff.rsv == $past(mgmtReq.wrData[10:7]))
    ) else $error("override write not stored");

    a_fault_latch: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        line.remoteFault ##1 !anyRead[*2] |-> st_ff.rfault
    ) else $error("remote fault not held");

    a_fault_clear: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (anyRead && !line.remoteFault) |=> !st_ff.rfault
    ) else $error("remote fault not cleared by read");

    a_jab_clear: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (altStatusRead && !line.jabber) |=> !st_ff.jabber
    ) else $error("jabber not cleared by alternate read");

    a_link_low: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !line.linkValid ##1 (line.linkValid && !selRead)
            |-> ##1 !st_ff.link
    ) else $error("link loss not latched");

    a_an_disabled: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !line.anEnabled |=> !st_ff.anDone
    ) else $error("negotiation done set while disabled");

    a_valid_pulse: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !selRead |=> !rdValid
    ) else $error("read valid without a status read");

    a_data_holds: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !selRead |=> $stable(rdData)
    ) else $error("read data changed without a status read");

    a_tx_full_rst: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        $rose(rstnSync) |-> st_ff.cap[3]
    ) else $error("bit 14 not one after reset");

    a_tx_half_rst: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        $rose(rstnSync) |-> st_ff.cap[2]
    ) else $error("bit 13 not one after reset");

    a_ten_full_rst: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        $rose(rstnSync) |-> st_ff.cap[1]
    ) else $error("bit 12 not one after reset");

    a_rsv_reset: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        $rose(rstnSync) |-> (st_ff.rsv == ps_pkg::RSV_RST)
    ) else $error("reserved bits not zero after reset");

    a_pre_reset: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        $rose(rstnSync) |-> (st_ff.preamble == ps_pkg::PRE_RST)
    ) else $error("bit 6 not zero after reset");

    a_rst_latches: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        $rose(rstnSync) |-> (!st_ff.rfault && !st_ff.jabber && !rdValid
            && rdData == 16'h0000)
    ) else $error("latched bits or read port not cleared by reset");

    a_pre_blocked: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !(selWrite && overrideEn) |=> $stable(st_ff.preamble)
    ) else $error("bit 6 changed without enabled write");

    a_pre_written: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (selWrite && overrideEn) |=> (st_ff.preamble
            == $past(mgmtReq.wrData[ps_pkg::PRE_BIT]))
    ) else $error("bit 6 override write not stored");

    a_ext_one: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        rdValid |-> rdData[ps_pkg::EXT_BIT]
    ) else $error("extended capability bit not one");

    a_able_one: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        rdValid |-> rdData[ps_pkg::AN_ABLE_BIT]
    ) else $error("negotiation ability bit not one");

    a_fault_set: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        line.remoteFault |=> st_ff.rfault
    ) else $error("remote fault not set by event");

    a_fault_rise: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !line.remoteFault |=> !$rose(st_ff.rfault)
    ) else $error("remote fault set without event");

    a_fault_alt: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (altStatusRead && !line.remoteFault) |=> !st_ff.rfault
    ) else $error("remote fault not cleared by alternate read");

    a_jab_set: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        line.jabber |=> st_ff.jabber
    ) else $error("jabber not set by event");

    a_jab_latch: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        line.jabber ##1 !anyRead[*2] |-> st_ff.jabber
    ) else $error("jabber not held");

    a_jab_rise: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !line.jabber |=> !$rose(st_ff.jabber)
    ) else $error("jabber set without event");

    a_jab_rd_clear: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (selRead && !line.jabber) |=> !st_ff.jabber
    ) else $error("jabber not cleared by status read");

    a_link_drop: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !line.linkValid |=> !st_ff.link
    ) else $error("link loss not seen next cycle");

    a_link_reload: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (selRead && line.linkValid) |=> st_ff.link
    ) else $error("link not reloaded by status read");

    a_link_hold: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (!selRead && line.linkValid) |=> $stable(st_ff.link)
    ) else $error("link bit changed without read or loss");

    a_an_set: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (line.anEnabled && line.anComplete) |=> st_ff.anDone
    ) else $error("negotiation done not set on completion");

    a_an_hold: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (st_ff.anDone && !selRead && line.anEnabled) |=> st_ff.anDone
    ) else $error("negotiation done dropped without read");

    a_an_clear: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        (selRead && !line.anComplete) |=> !st_ff.anDone
    ) else $error("negotiation done not cleared by read");

    a_an_rise: assert property (
        @(posedge core_clk) disable iff (!rstnSync)
        !(line.anEnabled && line.anComplete) |=> !$rose(st_ff.anDone)
    ) else $error("negotiation done set without completion");

endmodule

// ===== verification/ps_mgmt_station.sv
// Management station model issuing status register requests
`timescale 1ns/1ns
module ps_mgmt_station (
    input  wire logic                 core_clk,
    input  wire logic [15:0]          rdData,
    input  wire logic                 rdValid,
    output      ps_pkg::ps_mgmt_req_s mgmtReq
);
    initial mgmtReq = '0;

    task automatic wr(input logic [15:0] d);
        @(posedge core_clk);
        #1;
        mgmtReq.wrStb   = 1'h1;
        mgmtReq.regAddr = ps_pkg::STATUS_ADDR;
        mgmtReq.wrData  = {d[15:11], ps_pkg::RSV_RST, d[6:0]};
        @(posedge core_clk);
        #1;
        mgmtReq.wrStb   = 1'h0;
        mgmtReq.regAddr = ~mgmtReq.regAddr;
        mgmtReq.wrData  = ~mgmtReq.wrData;
    endtask

    task automatic rd(input logic [4:0] a, output logic v,
                      output logic [15:0] d);
        @(posedge core_clk);
        #1;
        mgmtReq.rdStb   = 1'h1;
        mgmtReq.regAddr = a;
        @(posedge core_clk);
        #1;
        v = rdValid;
        d = rdData;
        mgmtReq.rdStb   = 1'h0;
        mgmtReq.regAddr = ~a;
    endtask
endmodule

// ===== verification/testbench.sv
// Self-checking bench for the port status register
`timescale 1ns/1ns
`define CHK(nm, e, s) begin compares++; if ((e) !== (s)) begin \
    nMismatch++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module testbench;
    logic                 core_clk;
    logic                 rstn;
    logic                 altStatusRead;
    logic                 overrideEn;
    ps_pkg::ps_line_s     line;
    ps_pkg::ps_mgmt_req_s mgmtReq;
    logic [15:0]          rdData;
    logic                 rdValid;
    logic [15:0]          dat;
    logic [15:0]          rnd;
    logic                 vld;
    logic [8:0]           ow;
    int                   nMismatch = 0;
    int                   compares = 0;
    int                   cycles = 0;

    ps_status_reg ps_status_reg_inst (
        .core_clk(core_clk), .rstn(rstn), .mgmtReq(mgmtReq),
        .altStatusRead(altStatusRead), .overrideEn(overrideEn),
        .line(line), .rdData(rdData), .rdValid(rdValid));
    ps_mgmt_station ps_mgmt_station_inst (
        .core_clk(core_clk), .rdData(rdData), .rdValid(rdValid),
        .mgmtReq(mgmtReq));

    // Image from override bits 14..6 and flags {anDone,rfault,link,jabber}
    function automatic logic [15:0] img(input logic [8:0] o,
                                        input logic [3:0] f);
        return {1'h0, o, f[3], f[2], 1'h1, f[1], f[0], 1'h1};
    endfunction

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic summarize();
        $display("Mismatches %0d of %0d compares", nMismatch, compares);
        if (nMismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic doReset();
        rstn = 1'h0;
        repeat (2) tick();
        rstn = 1'h1;
        repeat (3) tick();
        ow = 9'h1E0;
    endtask

    task automatic rdChk(input string nm, input logic [15:0] e);
        ps_mgmt_station_inst.rd(ps_pkg::STATUS_ADDR, vld, dat);
        `CHK(nm, 1'h1, vld)
        `CHK(nm, e, dat)
    endtask

    // Toggle selected line inputs for one cycle
    task automatic pls(input logic [4:0] m);
        line = line ^ m;
        tick();
        line = line ^ m;
    endtask

    initial begin
        core_clk = 1'h0;
        forever #50 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            nMismatch++;
            summarize();
        end
    end

    initial begin
        rstn = 1'h0;
        altStatusRead = 1'h0;
        overrideEn = 1'h0;
        line = 5'h10;
        void'($urandom(25));
        doReset();
        rdChk("reset", 16'h7809);
        tick();
        `CHK("vldfall", 1'h0, rdValid)
        `CHK("hold", 16'h7809, rdData)
        rdChk("linkup", img(ow, 4'h2));
        ps_mgmt_station_inst.rd(5'h02, vld, dat);
        `CHK("badaddr", 1'h0, vld)
        for (int i = 0; i < 4; i++) begin
            rnd = 16'($urandom);
            ps_mgmt_station_inst.wr(rnd);
            rdChk("wroff", img(ow, 4'h2));
        end
        overrideEn = 1'h1;
        ps_mgmt_station_inst.wr(16'hFFFF);
        rdChk("wrmax", img(9'h1E1, 4'h2));
        ps_mgmt_station_inst.wr(16'h0000);
        rdChk("wrmin", img(9'h000, 4'h2));
        for (int i = 0; i < 4; i++) begin
            rnd = 16'($urandom);
            ps_mgmt_station_inst.wr(rnd);
            ow = {rnd[14:11], 4'h0, rnd[6]};
            rdChk("wron", img(ow, 4'h2));
        end
        overrideEn = 1'h0;
        pls(5'h08);
        rdChk("rfset", img(ow, 4'h6));
        rdChk("rfclr", img(ow, 4'h2));
        pls(5'h04);
        rdChk("jabset", img(ow, 4'h3));
        rdChk("jabclr", img(ow, 4'h2));
        line = line ^ 5'h0C;
        rdChk("evhold", img(ow, 4'h7));
        line = line ^ 5'h0C;
        rdChk("setwins", img(ow, 4'h7));
        rdChk("evclr", img(ow, 4'h2));
        pls(5'h0C);
        altStatusRead = 1'h1;
        tick();
        altStatusRead = 1'h0;
        rdChk("altclr", img(ow, 4'h2));
        pls(5'h10);
        rdChk("linklo", img(ow, 4'h0));
        rdChk("linkhi", img(ow, 4'h2));
        line.anEnabled = 1'h1;
        rdChk("anbusy", img(ow, 4'h2));
        pls(5'h01);
        rdChk("anset", img(ow, 4'hA));
        rdChk("anclr", img(ow, 4'h2));
        line.anEnabled = 1'h0;
        pls(5'h01);
        rdChk("anoff", img(ow, 4'h2));
        overrideEn = 1'h1;
        ps_mgmt_station_inst.wr(16'($urandom));
        doReset();
        rdChk("rereset", 16'h7809);
        summarize();
    end
endmodule
